// file: pkg/pmcm_pkg.sv
/*
 * pmcm_pkg: constants and types for the power-mode and clock manager.
 * Assumes a single 50 MHz control clock; oscillator sources are modelled
 * as ready/running flags plus sampled clock inputs.
 */
package pmcm_pkg;
	// clock_source_select encodings
	localparam logic [1:0] SEL_DEFAULT = 2'h0; // primary or internal by config
	localparam logic [1:0] SEL_SECONDARY = 2'h1;
	localparam logic [1:0] SEL_PRIMARY = 2'h2;
	localparam logic [1:0] SEL_INTERNAL = 2'h3;
	// oscillator control register field positions
	localparam int IDLE_BIT = 7;
	localparam int PRI_ACTIVE_BIT = 3;
	localparam int SEL_LSB = 0;
	// reset values
	localparam logic [1:0] SEL_RESET = 2'h0;
	localparam logic IDLE_RESET = 1'b0;
	// switch pause: old-source and new-source edge counts
	localparam int OLD_EDGES = 2;
	localparam int NEW_EDGES = 4; // upper end of three to four
	// cpu ready delay after a wake, in ns, and its cycle count at 50 MHz
	localparam int CLK_PERIOD_NS = 20;
	localparam int CPU_READY_NS = 200;
	localparam int CPU_READY_CYCLES = (CPU_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// source identifiers
	typedef enum logic [1:0] {SRC_NONE, SRC_PRIMARY, SRC_SECONDARY, SRC_INTERNAL} src_t;
endpackage : pmcm_pkg

// file: hw/power_mode_clock_manager.sv
/*
 * power_mode_clock_manager: run/idle/sleep sequencing and glitch-free
 * selection among primary, secondary and internal oscillators.
 * Assumes oscillator clocks arrive as slow asynchronous levels that are
 * sampled by i_clk; the gated clocks out are registered enables/levels.
 */
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - select write switches clock when source runs
// - power-down instruction alone enters sleep/idle
// - idle bit sampled at each power-down
// - sleep stops cpu and peripheral clocks
// - select 10 runs everything from primary
// - switch pauses two old, four new edges
// - status flags show primary or secondary source
// - select 01 moves to secondary, stops primary
// - secondary disabled blocks entry; unstarted withholds clocks
// - secondary to primary waits primary ready
// - select 11 runs from internal, stops primary
// - internal to primary waits; internal stays for watchdog
// - reset gives primary run, unless two-speed or config maps 00 to internal
// - sleep stops oscillator, clears flags, keeps needed
// - sleep wake waits source or uses internal
// - idle gates cpu only, flags unchanged
// - idle exit by event, after cpu delay
// - watchdog wakes to selected run; bits kept
// - idle bit 7, status bit 3, select 1:0
// - reset clears select; config maps 00
module power_mode_clock_manager #(
	parameter int READY_CYCLES = pmcm_pkg::CPU_READY_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_ctl_we,               // control register write strobe
	input wire logic [7:0] i_ctl_wdata,      // control register write data
	input wire logic i_power_down,           // power-down instruction executed
	input wire logic i_interrupt,            // wake by interrupt
	input wire logic i_wdt_timeout,          // watchdog time-out
	input wire logic i_reset_source_choice,  // config: 00 means primary
	input wire logic i_two_speed_en,         // two-speed start-up enabled
	input wire logic i_failsafe_en,          // fail-safe monitor enabled
	input wire logic i_wdt_en,               // watchdog enabled
	input wire logic i_secondary_osc_enable, // secondary oscillator enabled
	input wire logic i_primary_ready,        // primary oscillator stable
	input wire logic i_secondary_running,    // secondary oscillating
	input wire logic i_primary_clk,          // primary source clock
	input wire logic i_secondary_clk,        // secondary source clock
	input wire logic i_internal_clk,         // internal rc clock
	output logic [7:0] o_ctl_rdata,          // control register readback
	output logic o_secondary_clock_active,   // secondary flag
	output logic o_primary_osc_en,           // primary oscillator enable
	output logic o_secondary_osc_run,        // keep secondary running
	output logic o_internal_osc_en,          // internal oscillator enable
	output logic o_cpu_clk,                  // gated cpu clock
	output logic o_periph_clk,               // gated peripheral clock
	output logic o_cpu_run                   // cpu may execute
);
	initial begin
		assert (READY_CYCLES >= 1 && READY_CYCLES < 256)
			else $error("ready cycles out of range");
	end

	// operating modes of the sequencer:
	// run: cpu and peripherals clocked from the current source
	// wait_src: new source requested, old one still clocking unless the target is secondary
	// switch: glitch-free pause, both gated clocks held low
	// idle / sleep: cpu gated / everything gated
	// wake: cpu held off for the ready delay after an idle exit
	typedef enum logic [2:0] {ST_RUN, ST_SWITCH, ST_WAIT_SRC, ST_IDLE, ST_SLEEP, ST_WAKE} mode_t;

	// all state in one struct
	// one flop image keeps reset and next-state in a single place;
	// the price is that every field is rewritten on every edge
	// synchroniser bits live here too, so they reset with the rest
	typedef struct packed {
		mode_t mode;
		logic idle_bit;              // idle_on_sleep
		logic [1:0] sel;             // clock_source_select
		pmcm_pkg::src_t cur;         // source now clocking
		pmcm_pkg::src_t tgt;         // source being switched to
		logic [2:0] old_cnt;         // old-source edges counted
		logic [2:0] new_cnt;         // new-source edges counted
		logic [7:0] ready_cnt;       // cpu ready delay
		logic pri_act;
		logic sec_act;
		logic pri_en;
		logic [2:0] s_pri;           // primary clock sync + edge history
		logic [2:0] s_sec;
		logic [2:0] s_int;
		logic [1:0] s_prdy;
		logic [1:0] s_srun;
		logic cpu_clk;
		logic per_clk;
		logic cpu_run;
	} state_t;

	state_t state_reg;
	state_t state_next;

	// map a select code to a source
	// code 00 is the only one whose meaning depends on configuration,
	// so the config bit is looked at live rather than latched
	function automatic pmcm_pkg::src_t decode_sel(input logic [1:0] sel, input logic cfg);
		case (sel)
			pmcm_pkg::SEL_SECONDARY: decode_sel = pmcm_pkg::SRC_SECONDARY;
			pmcm_pkg::SEL_PRIMARY: decode_sel = pmcm_pkg::SRC_PRIMARY;
			pmcm_pkg::SEL_INTERNAL: decode_sel = pmcm_pkg::SRC_INTERNAL;
			default: decode_sel = cfg ? pmcm_pkg::SRC_PRIMARY : pmcm_pkg::SRC_INTERNAL;
		endcase
	endfunction : decode_sel

	// rising edge seen on a synchronised source
	// only bits 1 and 2 are compared: bit 0 may still be metastable
	// sources must run below half of i_clk or edges are lost
	function automatic logic rise(input logic [2:0] s);
		rise = s[1] & ~s[2];
	endfunction : rise

	// level of the synchronised source
	// no source selected gives a steady low, never a stale level
	function automatic logic lvl(input pmcm_pkg::src_t s, input state_t st);
		case (s)
			pmcm_pkg::SRC_PRIMARY: lvl = st.s_pri[1];
			pmcm_pkg::SRC_SECONDARY: lvl = st.s_sec[1];
			pmcm_pkg::SRC_INTERNAL: lvl = st.s_int[1];
			default: lvl = 1'b0;
		endcase
	endfunction : lvl

	// edge on the chosen source
	// used to count the old- and new-source halves of the pause
	function automatic logic edge_of(input pmcm_pkg::src_t s, input state_t st);
		case (s)
			pmcm_pkg::SRC_PRIMARY: edge_of = rise(st.s_pri);
			pmcm_pkg::SRC_SECONDARY: edge_of = rise(st.s_sec);
			pmcm_pkg::SRC_INTERNAL: edge_of = rise(st.s_int);
			default: edge_of = 1'b0;
		endcase
	endfunction : edge_of

	// new source able to clock: primary stable, secondary oscillating
	// both status inputs are synchronised copies; the rc source is
	// taken as always running, although o_internal_osc_en can switch it off
	function automatic logic src_ok(input pmcm_pkg::src_t s, input state_t st);
		case (s)
			pmcm_pkg::SRC_PRIMARY: src_ok = st.s_prdy[1];
			pmcm_pkg::SRC_SECONDARY: src_ok = st.s_srun[1];
			pmcm_pkg::SRC_INTERNAL: src_ok = 1'b1;
			default: src_ok = 1'b0;
		endcase
	endfunction : src_ok

	// next-state logic
	always_comb begin
		pmcm_pkg::src_t want;
		logic wake;
		state_next = state_reg;
		want = decode_sel(state_reg.sel, i_reset_source_choice);
		wake = i_interrupt | i_wdt_timeout;
		// inputs from other domains pass two flops before use
		state_next.s_pri = {state_reg.s_pri[1:0], i_primary_clk};
		state_next.s_sec = {state_reg.s_sec[1:0], i_secondary_clk};
		state_next.s_int = {state_reg.s_int[1:0], i_internal_clk};
		state_next.s_prdy = {state_reg.s_prdy[0], i_primary_ready};
		state_next.s_srun = {state_reg.s_srun[0], i_secondary_running};
		// software writes idle bit and select; wakes never touch them
		if (i_ctl_we) begin
			state_next.idle_bit = i_ctl_wdata[pmcm_pkg::IDLE_BIT];
			state_next.sel = i_ctl_wdata[pmcm_pkg::SEL_LSB +: 2];
		end
		// default gated clocks follow the current source
		state_next.cpu_clk = lvl(state_reg.cur, state_reg);
		state_next.per_clk = lvl(state_reg.cur, state_reg);
		// mode sequencer; each branch only overrides what it must,
		// everything else keeps the defaults set above
		// wake events outside idle or sleep are ignored here
		case (state_reg.mode)
			ST_RUN: begin
				state_next.cpu_run = 1'b1;
				if (i_power_down) begin
					if (state_reg.idle_bit) begin
						// secondary idle refused when its oscillator is off
						if (!(state_reg.cur == pmcm_pkg::SRC_SECONDARY && !i_secondary_osc_enable)) begin
							state_next.mode = ST_IDLE;
							state_next.cpu_run = 1'b0;
							state_next.cpu_clk = 1'b0;
						end
					end else begin
						state_next.mode = ST_SLEEP;
						state_next.cpu_run = 1'b0;
						state_next.cpu_clk = 1'b0;
						state_next.per_clk = 1'b0;
						state_next.pri_act = 1'b0;
						state_next.sec_act = 1'b0;
						state_next.pri_en = 1'b0;
						state_next.cur = pmcm_pkg::SRC_NONE;
					end
				end else if (want != state_reg.cur) begin
					if (want == pmcm_pkg::SRC_SECONDARY && !i_secondary_osc_enable) begin
						state_next.mode = ST_RUN; // entry refused
					end else begin
						state_next.tgt = want;
						if (want == pmcm_pkg::SRC_PRIMARY)
							state_next.pri_en = 1'b1;
						// stay on old source until new is ready
						state_next.mode = ST_WAIT_SRC;
					end
				end
			end
			ST_WAIT_SRC: begin
				// later select writes are stored but not acted on until
				// this switch completes and run compares again
				// secondary enabled but not oscillating withholds clocks
				if (state_reg.tgt == pmcm_pkg::SRC_SECONDARY) begin
					state_next.cpu_clk = 1'b0;
					state_next.per_clk = 1'b0;
					state_next.cpu_run = 1'b0;
				end
				if (src_ok(state_reg.tgt, state_reg)) begin
					state_next.mode = ST_SWITCH;
					state_next.old_cnt = 3'h0;
					state_next.new_cnt = 3'h0;
					state_next.cpu_run = 1'b0;
				end
			end
			ST_SWITCH: begin
				// two old-source edges, then four new-source edges
				// with no old source (sleep wake) the first half is a
				// plain two-cycle count so the switch cannot stall
				// mux output held low through the pause
				state_next.cpu_clk = 1'b0;
				state_next.per_clk = 1'b0;
				state_next.cpu_run = 1'b0;
				if (state_reg.old_cnt < 3'(pmcm_pkg::OLD_EDGES)) begin
					if (edge_of(state_reg.cur, state_reg) || state_reg.cur == pmcm_pkg::SRC_NONE)
						state_next.old_cnt = state_reg.old_cnt + 3'h1;
				end else if (state_reg.new_cnt < 3'(pmcm_pkg::NEW_EDGES)) begin
					if (edge_of(state_reg.tgt, state_reg))
						state_next.new_cnt = state_reg.new_cnt + 3'h1;
				end else begin
					state_next.cur = state_reg.tgt;
					state_next.mode = ST_RUN;
					state_next.cpu_run = 1'b1;
					// flags follow the source now clocking
					state_next.pri_act = (state_reg.tgt == pmcm_pkg::SRC_PRIMARY);
					state_next.sec_act = (state_reg.tgt == pmcm_pkg::SRC_SECONDARY);
					// primary off when leaving it; secondary left running
					if (state_reg.tgt != pmcm_pkg::SRC_PRIMARY)
						state_next.pri_en = 1'b0;
				end
			end
			ST_IDLE: begin
				// peripherals keep their clock; flags untouched
				state_next.cpu_clk = 1'b0;
				state_next.cpu_run = 1'b0;
				if (wake) begin
					state_next.mode = ST_WAKE;
					state_next.ready_cnt = 8'(READY_CYCLES);
				end
			end
			ST_SLEEP: begin
				// nothing is clocked; a wake either waits for the chosen
				// source or, with two-speed or fail-safe, starts at once
				// from the rc source and leaves the switch to run mode
				state_next.cpu_clk = 1'b0;
				state_next.per_clk = 1'b0;
				state_next.cpu_run = 1'b0;
				if (wake) begin
					if (i_two_speed_en || i_failsafe_en) begin
						state_next.cur = pmcm_pkg::SRC_INTERNAL;
						state_next.tgt = want;
						state_next.pri_en = (want == pmcm_pkg::SRC_PRIMARY);
						state_next.mode = ST_RUN;
					end else begin
						state_next.tgt = want;
						state_next.pri_en = (want == pmcm_pkg::SRC_PRIMARY);
						state_next.mode = ST_WAIT_SRC; // no clock until ready
					end
				end
			end
			ST_WAKE: begin
				// cpu held while it becomes ready
				state_next.cpu_clk = 1'b0;
				state_next.cpu_run = 1'b0;
				if (state_reg.ready_cnt <= 8'h1) begin
					state_next.mode = ST_RUN;
					state_next.cpu_run = 1'b1;
				end else begin
					state_next.ready_cnt = state_reg.ready_cnt - 8'h1;
				end
			end
			default: state_next.mode = ST_RUN;
		endcase
		// synchronous reset: primary run when config maps 00 to primary, unless two-speed start
		// placed last so it overrides every branch above
		// two-speed start runs from rc while primary is enabled,
		// then the normal run-mode compare moves it to primary
		if (i_srst) begin
			state_next = '0;
			state_next.mode = ST_RUN;
			state_next.sel = pmcm_pkg::SEL_RESET;
			state_next.idle_bit = pmcm_pkg::IDLE_RESET;
			state_next.cpu_run = 1'b1;
			if (!i_two_speed_en && i_reset_source_choice) begin
				state_next.cur = pmcm_pkg::SRC_PRIMARY;
				state_next.pri_act = 1'b1;
				state_next.pri_en = 1'b1;
			end else begin
				state_next.cur = pmcm_pkg::SRC_INTERNAL;
				state_next.pri_en = i_reset_source_choice;
			end
		end
	end

	// state register
	always_ff @(posedge i_clk) begin
		state_reg <= state_next;
	end

	// outputs straight from flops
	// loaded from the next-state image so they match the state
	// register edge for edge, with no extra cycle of lag
	// the secondary keep-running output simply follows its enable
	always_ff @(posedge i_clk) begin
		o_ctl_rdata <= {state_next.idle_bit, 3'h0, state_next.pri_act, 1'b0, state_next.sel};
		o_secondary_clock_active <= state_next.sec_act;
		o_primary_osc_en <= state_next.pri_en;
		o_secondary_osc_run <= i_secondary_osc_enable;
		o_internal_osc_en <= (state_next.cur == pmcm_pkg::SRC_INTERNAL) | i_wdt_en | i_failsafe_en;
		o_cpu_clk <= state_next.cpu_clk;
		o_periph_clk <= state_next.per_clk;
		o_cpu_run <= state_next.cpu_run;
	end
endmodule : power_mode_clock_manager

`default_nettype wire

// file: dv/pmcm_chk.sv
/* pmcm_chk: port assertions for the power-mode clock manager.
   Assumes bind onto the design top, one clock domain, sync reset. */
`timescale 1ns/1ps
`default_nettype none
module pmcm_chk #(
	parameter int READY_CYCLES = 2
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_ctl_we,
	input wire logic [7:0] i_ctl_wdata,
	input wire logic i_power_down,
	input wire logic i_interrupt,
	input wire logic i_wdt_timeout,
	input wire logic i_two_speed_en,
	input wire logic i_reset_source_choice,
	input wire logic i_secondary_osc_enable,
	input wire logic [7:0] o_ctl_rdata,
	input wire logic o_secondary_clock_active,
	input wire logic o_primary_osc_en,
	input wire logic o_cpu_clk,
	input wire logic o_periph_clk,
	input wire logic o_cpu_run
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_srst);
	logic idle_reg; // cpu parked in an idle mode
	logic idle_next;
	// tracks idle so wake timing is judged only where it applies
	always_comb begin
		idle_next = idle_reg;
		if (i_srst || o_cpu_run) idle_next = i_power_down && o_ctl_rdata[7] && !i_srst;
	end
	always_ff @(posedge i_clk) begin
		idle_reg <= idle_next;
	end
	property p_rst;
		$fell(i_srst) && i_reset_source_choice && !i_two_speed_en |->
			o_ctl_rdata == 8'h08 && !o_secondary_clock_active && o_cpu_run;
	endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
	property p_wr;
		i_ctl_we |=> (o_ctl_rdata & 8'hF7) == ($past(i_ctl_wdata) & 8'h83);
	endproperty
	a_wr: assert property (p_wr) else $error("control readback wrong");
	property p_keep;
		!i_ctl_we |=> $stable({o_ctl_rdata[7], o_ctl_rdata[1:0]});
	endproperty
	a_keep: assert property (p_keep) else $error("control bits moved");
	property p_one;
		!(o_ctl_rdata[3] && o_secondary_clock_active);
	endproperty
	a_one: assert property (p_one) else $error("two source flags set");
	property p_sleep;
		i_power_down && !o_ctl_rdata[7] && o_cpu_run |=> !o_cpu_run && !o_cpu_clk
			&& !o_periph_clk && !o_ctl_rdata[3] && !o_secondary_clock_active;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep entry wrong");
	property p_idle;
		i_power_down && o_ctl_rdata[7] && o_cpu_run |=> !o_cpu_run && !o_cpu_clk
			&& $stable(o_ctl_rdata[3]) && $stable(o_secondary_clock_active);
	endproperty
	a_idle: assert property (p_idle) else $error("idle entry wrong");
	property p_wake;
		idle_reg && !o_cpu_run && (i_interrupt || i_wdt_timeout) |=> !o_cpu_run ##[1:12] o_cpu_run;
	endproperty
	a_wake: assert property (p_wake) else $error("idle wake timing wrong");
	property p_rc;
		i_ctl_we && i_ctl_wdata[1:0] == 2'h3 && o_cpu_run |->
			##[1:400] !o_primary_osc_en && !o_ctl_rdata[3];
	endproperty
	a_rc: assert property (p_rc) else $error("internal run not reached");
	property p_sec;
		i_ctl_we && i_ctl_wdata[1:0] == 2'h1 && i_secondary_osc_enable |->
			##[1:400] o_secondary_clock_active && !o_ctl_rdata[3];
	endproperty
	a_sec: assert property (p_sec) else $error("secondary run not reached");
	property p_nosec;
		i_ctl_we && i_ctl_wdata[1:0] == 2'h1 && !i_secondary_osc_enable
			&& !o_secondary_clock_active |=> !o_secondary_clock_active [*8];
	endproperty
	a_nosec: assert property (p_nosec) else $error("secondary entered while off");
	c_sleep: cover property (i_power_down && !o_ctl_rdata[7] && o_cpu_run);
	c_idle: cover property (i_power_down && o_ctl_rdata[7] && o_cpu_run);
	c_sec: cover property ($rose(o_secondary_clock_active));
endmodule : pmcm_chk
bind power_mode_clock_manager pmcm_chk #(.READY_CYCLES(READY_CYCLES)) u_chk (
	.i_clk(i_clk), .i_srst(i_srst), .i_ctl_we(i_ctl_we), .i_ctl_wdata(i_ctl_wdata),
	.i_power_down(i_power_down), .i_interrupt(i_interrupt), .i_wdt_timeout(i_wdt_timeout),
	.i_two_speed_en(i_two_speed_en), .i_reset_source_choice(i_reset_source_choice),
	.i_secondary_osc_enable(i_secondary_osc_enable), .o_ctl_rdata(o_ctl_rdata),
	.o_secondary_clock_active(o_secondary_clock_active), .o_primary_osc_en(o_primary_osc_en),
	.o_cpu_clk(o_cpu_clk), .o_periph_clk(o_periph_clk), .o_cpu_run(o_cpu_run));
`default_nettype wire

// file: dv/osc_model.sv
/* osc_model: primary, secondary and internal oscillator stand-ins.
   Assumes i_clk is the control clock; sources are slow divisions of it. */
`timescale 1ns/1ps
`default_nettype none
module osc_model (
	input wire logic i_clk,
	input wire logic i_primary_osc_en,
	input wire logic i_secondary_osc_enable,
	output logic o_primary_clk,
	output logic o_secondary_clk,
	output logic o_internal_clk,
	output logic o_primary_ready,
	output logic o_secondary_running
);
	logic [4:0] div_reg = 5'h00; // free divider
	logic [4:0] pri_age_reg = 5'h00; // cycles since primary enabled
	logic [3:0] sec_age_reg = 4'h0; // cycles since secondary enabled
	// start-up ages; a stopped source starts over, so wakes see a real wait
	always_ff @(posedge i_clk) begin
		div_reg <= div_reg + 5'h01;
		pri_age_reg <= i_primary_osc_en ? pri_age_reg + {4'h0, pri_age_reg != 5'h1F} : 5'h00;
		sec_age_reg <= i_secondary_osc_enable ? sec_age_reg + {3'h0, sec_age_reg != 4'hF} : 4'h0;
	end
	// stopped sources sit low rather than hold a last level
	assign o_primary_ready = pri_age_reg == 5'h1F;
	assign o_secondary_running = sec_age_reg == 4'hF; // enabled but slow to start
	assign o_primary_clk = i_primary_osc_en && div_reg[2];
	assign o_secondary_clk = o_secondary_running && div_reg[3];
	assign o_internal_clk = div_reg[4]; // rc runs free
endmodule : osc_model
`default_nettype wire

// file: dv/tb_top.sv
/* tb_top: self-checking bench for the power-mode clock manager.
   Assumes osc_model and the bound checker are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin num_errors++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
`define WAITC(c) for (n = 0; n < 400 && !(c); n++) @(negedge i_clk); if (n >= 400) begin num_errors++; $display("[ERR] %0t wait timed out", $time); end
module tb_top;
	logic i_clk = 1'b0;
	logic i_srst, i_ctl_we, i_power_down, i_interrupt, i_wdt_timeout, sec_en, idle;
	logic [7:0] i_ctl_wdata, rdata;
	logic pri_clk, sec_clk, int_clk, pri_rdy, sec_ok;
	logic sec_act, pri_en, secondary_run, int_en, cpu_clk, periph_clk, cpu_run;
	logic [31:0] seed = 32'h3A468AE0; // fixed seed for repeatable runs
	logic rsc = 1'b1; // config: select 00 means primary
	logic ts = 1'b0; // two-speed start-up
	logic fs = 1'b0; // fail-safe monitor
	logic wdt_en = 1'b1; // watchdog enable
	int num_errors = 0;
	int samples_checked = 0;
	int n, i, per;
	// small ready delay keeps wake checks short
	power_mode_clock_manager #(.READY_CYCLES(2)) dut (.i_clk(i_clk), .i_srst(i_srst),
		.i_ctl_we(i_ctl_we), .i_ctl_wdata(i_ctl_wdata), .i_power_down(i_power_down),
		.i_interrupt(i_interrupt), .i_wdt_timeout(i_wdt_timeout), .i_reset_source_choice(rsc),
		.i_two_speed_en(ts), .i_failsafe_en(fs), .i_wdt_en(wdt_en),
		.i_secondary_osc_enable(sec_en), .i_primary_ready(pri_rdy), .i_secondary_running(sec_ok),
		.i_primary_clk(pri_clk), .i_secondary_clk(sec_clk), .i_internal_clk(int_clk),
		.o_ctl_rdata(rdata), .o_secondary_clock_active(sec_act), .o_primary_osc_en(pri_en),
		.o_secondary_osc_run(secondary_run), .o_internal_osc_en(int_en), .o_cpu_clk(cpu_clk),
		.o_periph_clk(periph_clk), .o_cpu_run(cpu_run));
	osc_model osc (.i_clk(i_clk), .i_primary_osc_en(pri_en), .i_secondary_osc_enable(sec_en),
		.o_primary_clk(pri_clk), .o_secondary_clk(sec_clk), .o_internal_clk(int_clk),
		.o_primary_ready(pri_rdy), .o_secondary_running(sec_ok));
	// expected readback: idle, status bit, select
	function automatic logic [7:0] exp_rd(logic id, logic pri, logic [1:0] sel);
		return {id, 3'h0, pri, 1'h0, sel};
	endfunction : exp_rd
	function automatic logic [31:0] xs(logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	// one-cycle control write, driven off the falling edge
	task automatic wr(input logic [7:0] d);
		@(negedge i_clk);
		i_ctl_we = 1'b1;
		i_ctl_wdata = d;
		@(negedge i_clk);
		i_ctl_we = 1'b0;
	endtask : wr
	task automatic wrap_up();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : wrap_up
	initial begin
		forever #10 i_clk = ~i_clk;
	end
	// hang guard, well past the expected run length
	initial begin
		repeat (30000) @(posedge i_clk);
		num_errors++;
		wrap_up();
	end
	initial begin
		{i_srst, i_ctl_we, i_power_down, i_interrupt, i_wdt_timeout, sec_en} = 6'h20;
		i_ctl_wdata = 8'h00;
		repeat (6) @(negedge i_clk);
		i_srst = 1'b0;
		@(negedge i_clk);
		`CHK(rdata, exp_rd(1'b0, 1'b1, 2'h0))
		`CHK(sec_act, 1'b0)
		wr(8'h03);
		`WAITC(!rdata[3] && !pri_en)
		`CHK(rdata, exp_rd(1'b0, 1'b0, 2'h3))
		wr(8'h02);
		`WAITC(rdata[3])
		`CHK(rdata, exp_rd(1'b0, 1'b1, 2'h2))
		`CHK(int_en, 1'b1)
		// refused: secondary still disabled
		wr(8'h01);
		repeat (60) @(negedge i_clk);
		`CHK({sec_act, rdata[3]}, 2'h1)
		sec_en = 1'b1;
		wr(8'h01);
		`WAITC(sec_act)
		`CHK(rdata, exp_rd(1'b0, 1'b0, 2'h1))
		`CHK(pri_en, 1'b0)
		wr(8'h02);
		`CHK({sec_act, cpu_run}, 2'h3)
		`WAITC(rdata[3])
		`CHK({sec_act, secondary_run}, 2'h1)
		// random idle or sleep entries, each woken by interrupt or watchdog
		for (i = 0; i < 8; i++) begin
			seed = xs(seed);
			idle = seed[0];
			wr({idle, 7'h02});
			`WAITC(rdata[3] && cpu_run)
			fs = !idle && seed[2];
			i_power_down = 1'b1;
			@(negedge i_clk);
			i_power_down = 1'b0;
			`CHK(cpu_run, 1'b0)
			`CHK(rdata[3], idle)
			per = 0;
			repeat (40) begin
				@(negedge i_clk);
				per += periph_clk;
			end
			`CHK(per != 0, idle)
			i_interrupt = seed[1];
			i_wdt_timeout = !seed[1];
			@(negedge i_clk);
			{i_interrupt, i_wdt_timeout} = 2'h0;
			`WAITC(cpu_run)
			`CHK(rdata, exp_rd(idle, !fs, 2'h2))
			fs = 1'b0;
		end
		// mid-run resets: rc default, then two-speed start
		wdt_en = 1'b0;
		@(negedge i_clk);
		{i_srst, rsc} = 2'b10;
		repeat (3) @(negedge i_clk);
		i_srst = 1'b0;
		@(negedge i_clk);
		`CHK(rdata, exp_rd(1'b0, 1'b0, 2'h0))
		`CHK({pri_en, int_en, cpu_run}, 3'h3)
		repeat (20) @(negedge i_clk);
		`CHK(rdata, exp_rd(1'b0, 1'b0, 2'h0))
		{i_srst, rsc, ts} = 3'b111;
		repeat (3) @(negedge i_clk);
		i_srst = 1'b0;
		@(negedge i_clk);
		`CHK({rdata[3], pri_en}, 2'h1)
		`WAITC(rdata[3])
		`CHK({rdata, int_en}, {exp_rd(1'b0, 1'b1, 2'h0), 1'b0})
		wrap_up();
	end
endmodule : tb_top
`default_nettype wire
